// file: tcu_pkg.sv
/*
  Shared constants and types for the bus timing and clock unit.
  Assumes a single system clock that is much faster than the clock source pin.
*/
package tcu_pkg;

  // ----------------------------------------------------------------
  // Pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int SY_EXT = 0;
  localparam int SY_RST = 1;
  localparam int SY_ADS = 2;
  localparam int SY_DIR = 3;
  localparam int SY_SLOW = 4;
  localparam int SY_CONTINUOUS_WAIT_N = 5;
  localparam int SY_WAIT = 6;
  localparam int WAIT_W = 4;
  localparam int SYNC_W = 10;
  // Idle pin levels: active-low pins high, clock and count low
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 10'h03E;

  // ----------------------------------------------------------------
  // Wait counter values
  // ----------------------------------------------------------------
  localparam logic [WAIT_W-1:0] WAIT_NONE = 4'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Slow cycle length and phase steps
  // ----------------------------------------------------------------
  localparam int SLOW_TSTATES_DEF = 2;
  localparam int SLOW_W = 4;
  localparam logic [SLOW_W-1:0] SLOW_ONE = 4'h1;
  localparam logic [1:0] STEP_PH1 = 2'h0;
  localparam logic [1:0] STEP_GAP1 = 2'h1;
  localparam logic [1:0] STEP_PH2 = 2'h2;
  localparam logic [1:0] STEP_GAP2 = 2'h3;
  localparam logic [1:0] STEP_GAP_BIT = 2'h1;

  // ----------------------------------------------------------------
  // Sequencer and wait generator states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TS_IDLE, TS_T1, TS_T2, TS_SLOW, TS_TW, TS_T3, TS_T4} tstate_t;
  typedef enum logic [1:0] {W_IDLE, W_COUNT, W_CONT} wmode_t;

endpackage

// file: phase_gen.sv
/*
  Divide-by-two and two-phase clock generator.
  Assumes ext_clk_sync is already synchronised to clk_sys and runs well below it.
*/
`timescale 1ns/1ps
module phase_gen (
  // Clock and reset
  input logic clk_sys,
  input logic reset,
  // Synchronised clock source
  input logic ext_clk_sync,
  // Generated clocks
  output logic phase1,
  output logic phase2,
  output logic half_clk,
  output logic fast_clk,
  output logic sys_tick
);
  import tcu_pkg::*;

  // ----------------------------------------------------------------
  // Edge detection and step counter
  // ----------------------------------------------------------------
  logic ext_d_r;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  logic rise;
  logic fall;

  // Both source edges are steps: four steps per half-rate period
  assign rise = ext_clk_sync & ~ext_d_r;
  assign fall = ~ext_clk_sync & ext_d_r;

  // Rising edges realign the step so phase 1 always follows a rise
  always_comb begin
    step_nxt = step_r;
    if (rise) begin
      step_nxt = (step_r == STEP_GAP2) ? STEP_PH1 : STEP_PH2;
    end else if (fall) begin
      step_nxt = step_r | STEP_GAP_BIT;
    end
  end

  // Step state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_d_r <= 1'b0;
      step_r <= STEP_GAP2;
    end else begin
      ext_d_r <= ext_clk_sync;
      step_r <= step_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registered clock outputs
  // ----------------------------------------------------------------
  // Gap steps between the phases keep their active parts apart
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase1 <= 1'b0;
      phase2 <= 1'b0;
      half_clk <= 1'b0;
      fast_clk <= 1'b0;
      sys_tick <= 1'b0;
    end else begin
      phase1 <= (step_nxt == STEP_PH1);
      phase2 <= (step_nxt == STEP_PH2);
      half_clk <= (step_nxt == STEP_PH1) | (step_nxt == STEP_GAP1);
      fast_clk <= ext_clk_sync;
      sys_tick <= (rise | fall) & (step_nxt == STEP_PH1);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  no_overlap_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(phase1 && phase2)) else $error("clock phases overlap");
  fast_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 fast_clk == $past(ext_clk_sync)) else $error("fast clock not undivided");
  tick_phase_a: assert property (@(posedge clk_sys) disable iff (reset)
    sys_tick |-> phase1 && half_clk && !$past(phase1)) else $error("tick off phase");
endmodule

// file: bus_timing_clock_unit.sv
/*
  Bus timing and clock unit: clock phases, reset and ready synchronisation,
  wait-state generation and bus strobes for a 16-bit processor bus.
  Assumes all pins are asynchronous to clk_sys and that clk_sys samples the
  clock source pin at least four times per source period.
*/
// Functional notes
// - Fast clock output equals source frequency
// - Source divided by two feeds phases
// - Two phases never active together
// - TTL system clock and internal tick
// - Reset input synchronised to reset output
// - Ready output synchronised to system clock
// - Either wait input inserts wait states
// - Four wait bits give zero to fifteen
// - Continuous wait holds without limit
// - Counted waits follow continuous wait release
// - Continuous wait overrides running count
// - Held cycle strobes regenerate after release
// - Read, write, buffer enable per cycle
// - Slow cycles lengthen strobe setup
// - Start pulse drops ready; release raises
// - Address strobe starts T1 counting
// - Direction and slow select latched at start
// - Marker pulses at T2 and last T-state
`timescale 1ns/1ps
module bus_timing_clock_unit #(
  parameter int SLOW_TSTATES = tcu_pkg::SLOW_TSTATES_DEF
) (
  // System clock and reset
  input logic clk_sys,
  input logic reset,
  // Clock source and generated clocks
  input logic external_clock_in,
  output logic phase1_out,
  output logic phase2_out,
  output logic ttl_system_clock_out,
  output logic fast_clock_out,
  // Reset path
  input logic raw_reset_in_n,
  output logic synced_reset_out_n,
  // Processor bus cycle inputs
  input logic address_strobe_in_n,
  input logic data_direction_in,
  input logic slow_cycle_n,
  // Wait inputs
  input logic continuous_wait_n,
  input logic [tcu_pkg::WAIT_W-1:0] wait_count_in,
  // Bus control outputs
  output logic ready_out,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic data_buffer_en_n,
  output logic t_state_marker_out
);
  import tcu_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_in;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic sys_tick;
  logic half_clk;

  assign pins_in = {wait_count_in, continuous_wait_n, slow_cycle_n, data_direction_in,
                    address_strobe_in_n, raw_reset_in_n, external_clock_in};

  // Two flops on every pin; only sync2_r feeds logic
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  phase_gen u_phase_gen (
    .clk_sys(clk_sys),
    .reset(reset),
    .ext_clk_sync(sync2_r[SY_EXT]),
    .phase1(phase1_out),
    .phase2(phase2_out),
    .half_clk(half_clk),
    .fast_clk(fast_clock_out),
    .sys_tick(sys_tick)
  );

  // TTL copy of the half-rate clock, one flop behind the phases
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ttl_system_clock_out <= 1'b0;
    end else begin
      ttl_system_clock_out <= half_clk;
    end
  end

  // Reset output changes only on the internal tick, so it is clean to the bus
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      synced_reset_out_n <= 1'b0;
    end else if (sys_tick) begin
      synced_reset_out_n <= sync2_r[SY_RST];
    end
  end

  // ----------------------------------------------------------------
  // Cycle start capture
  // ----------------------------------------------------------------
  logic ads_d_r;
  logic ads_fall;
  logic ads_pend_r;
  logic write_cyc_r;
  logic slow_cyc_r;
  tstate_t state_r;
  tstate_t state_nxt;

  assign ads_fall = ads_d_r & ~sync2_r[SY_ADS];

  // A strobe seen in the same cycle as the pending flag clears wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ads_d_r <= 1'b1;
      ads_pend_r <= 1'b0;
    end else begin
      ads_d_r <= sync2_r[SY_ADS];
      if (ads_fall) begin
        ads_pend_r <= 1'b1;
      end else if (state_nxt == TS_T1) begin
        ads_pend_r <= 1'b0;
      end
    end
  end

  // Cycle type is frozen at the strobe so later pin changes do not disturb it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      write_cyc_r <= 1'b0;
      slow_cyc_r <= 1'b0;
    end else if (ads_fall) begin
      write_cyc_r <= sync2_r[SY_DIR];
      slow_cyc_r <= ~sync2_r[SY_SLOW];
    end
  end

  // ----------------------------------------------------------------
  // Wait-state generator
  // ----------------------------------------------------------------
  wmode_t wait_mode_r;
  logic [WAIT_W-1:0] count_r;
  logic [WAIT_W-1:0] wait_in;
  logic [SLOW_W-1:0] slow_cnt_r;
  logic continuous_wait_n_on;
  logic start_pulse;
  logic wait_zone;
  logic wait_more;

  assign wait_in = sync2_r[SY_WAIT +: WAIT_W];
  assign continuous_wait_n_on = ~sync2_r[SY_CONTINUOUS_WAIT_N];
  assign start_pulse = sys_tick & (state_r == TS_T1);
  assign wait_zone = (state_r == TS_T2) | (state_r == TS_SLOW) | (state_r == TS_TW);

  // Whether another wait state follows the current T-state
  assign wait_more = continuous_wait_n_on | ((wait_mode_r == W_CONT) & (wait_in != WAIT_NONE)) |
                     ((wait_mode_r == W_COUNT) & ((state_r != TS_TW) | (count_r > WAIT_ONE)));

  // Mode and count advance on ticks only; decrement happens in wait states
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_mode_r <= W_IDLE;
      count_r <= WAIT_NONE;
    end else if (start_pulse) begin
      count_r <= wait_in;
      if (continuous_wait_n_on) begin
        wait_mode_r <= W_CONT;
      end else if (wait_in != WAIT_NONE) begin
        wait_mode_r <= W_COUNT;
      end else begin
        wait_mode_r <= W_IDLE;
      end
    end else if (sys_tick && wait_zone) begin
      if (continuous_wait_n_on) begin
        wait_mode_r <= W_CONT;
      end else if (wait_mode_r == W_CONT) begin
        count_r <= wait_in;
        wait_mode_r <= (wait_in != WAIT_NONE) ? W_COUNT : W_IDLE;
      end else if (wait_mode_r == W_COUNT && state_r == TS_TW) begin
        count_r <= count_r - WAIT_ONE;
        if (count_r == WAIT_ONE) begin
          wait_mode_r <= W_IDLE;
        end
      end
    end
  end

  // Slow cycle setup counter, loaded in T1
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slow_cnt_r <= SLOW_ONE;
    end else if (start_pulse) begin
      slow_cnt_r <= SLOW_W'(SLOW_TSTATES);
    end else if (sys_tick && state_r == TS_SLOW) begin
      slow_cnt_r <= slow_cnt_r - SLOW_ONE;
    end
  end

  // ----------------------------------------------------------------
  // T-state sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (sys_tick) begin
      unique case (state_r)
        TS_IDLE: if (ads_pend_r) state_nxt = TS_T1;
        TS_T1: state_nxt = TS_T2;
        TS_T2: begin
          if (slow_cyc_r) begin
            state_nxt = TS_SLOW;
          end else begin
            state_nxt = wait_more ? TS_TW : TS_T3;
          end
        end
        TS_SLOW: begin
          if (slow_cnt_r <= SLOW_ONE) begin
            state_nxt = wait_more ? TS_TW : TS_T3;
          end
        end
        TS_TW: state_nxt = wait_more ? TS_TW : TS_T3;
        TS_T3: state_nxt = TS_T4;
        TS_T4: state_nxt = TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= TS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Ready, marker and strobes
  // ----------------------------------------------------------------
  // Ready drops with the start pulse and rises as the wait releases into T3
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_out <= 1'b1;
    end else if (start_pulse) begin
      ready_out <= 1'b0;
    end else if (state_nxt == TS_T3 && state_r != TS_T3) begin
      ready_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      t_state_marker_out <= 1'b0;
    end else begin
      t_state_marker_out <= (state_nxt != state_r) &&
                            (state_nxt == TS_T2 || state_nxt == TS_T4);
    end
  end

  // Strobes drop during a continuous hold and come back on release, so a
  // held memory cycle is seen again by refresh or arbitration logic
  logic window;
  logic strobe_on;
  assign window = (state_r == TS_T3) | (state_r == TS_TW) | ((state_r == TS_T2) & ~slow_cyc_r);
  assign strobe_on = window & (wait_mode_r != W_CONT);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_buffer_en_n <= 1'b1;
    end else begin
      read_strobe_n <= ~(strobe_on & ~write_cyc_r);
      write_strobe_n <= ~(strobe_on & write_cyc_r);
      data_buffer_en_n <= ~(strobe_on | ((state_r == TS_T4) & write_cyc_r));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence cycle_start_s;
    sys_tick && state_r == TS_T1;
  endsequence
  sequence count_end_s;
    sys_tick && state_r == TS_TW && wait_mode_r == W_COUNT && count_r == WAIT_ONE && !continuous_wait_n_on;
  endsequence

  ready_drop_a: assert property (cycle_start_s |=> !ready_out)
    else $error("ready not dropped at start");
  count_end_a: assert property (count_end_s |=> state_r == TS_T3 && ready_out)
    else $error("count did not end wait");
  count_step_a: assert property (sys_tick && state_r == TS_TW && wait_mode_r == W_COUNT &&
    count_r > WAIT_ONE && !continuous_wait_n_on |=> count_r == $past(count_r) - WAIT_ONE && state_r == TS_TW)
    else $error("wait count did not step");
  cont_hold_a: assert property (sys_tick && state_r == TS_TW && continuous_wait_n_on |=>
    state_r == TS_TW && wait_mode_r == W_CONT) else $error("continuous wait not held");
  cont_defer_a: assert property (sys_tick && state_r == TS_TW && wait_mode_r == W_CONT &&
    !continuous_wait_n_on && wait_in != WAIT_NONE |=> wait_mode_r == W_COUNT && count_r == $past(wait_in))
    else $error("deferred count not loaded");
  count_override_a: assert property (sys_tick && wait_zone && wait_mode_r == W_COUNT &&
    continuous_wait_n_on |=> wait_mode_r == W_CONT) else $error("count not overridden");
  hold_strobe_a: assert property (wait_mode_r == W_CONT |=> read_strobe_n && write_strobe_n)
    else $error("strobe active during hold");
  marker_mark_a: assert property (t_state_marker_out |-> $changed(state_r) &&
    (state_r == TS_T2 || state_r == TS_T4)) else $error("marker off T2 or last");
  latch_type_a: assert property (ads_fall |=> write_cyc_r == $past(sync2_r[SY_DIR]))
    else $error("direction not latched");
  reset_sync_a: assert property (sys_tick |=> synced_reset_out_n == $past(sync2_r[SY_RST]))
    else $error("reset output not synchronised");
endmodule

// file: cpu_bus_model.sv
/*
  Processor side of the bus: free-running clock source and bus cycle requests.
  Assumes clk_sys is the bench clock and the source half period is SRC_HALF clocks.
*/
`timescale 1ns/1ps
module cpu_bus_model #(
  parameter int SRC_HALF = 4
) (
  // Bench clock
  input wire logic clk_sys,
  // Source clock and cycle request
  output logic external_clock_in,
  output logic address_strobe_in_n,
  output logic data_direction_in,
  output logic slow_cycle_n
);
  int ph_cnt = 0;

  // Idle bus at time zero
  initial begin
    external_clock_in = 1'b0;
    address_strobe_in_n = 1'b1;
    data_direction_in = 1'b0;
    slow_cycle_n = 1'b1;
  end

  // A crystal never stops, so the source runs between cycles too
  always @(posedge clk_sys) begin
    ph_cnt <= (ph_cnt == SRC_HALF - 1) ? 0 : ph_cnt + 1;
    if (ph_cnt == SRC_HALF - 1) begin
      external_clock_in <= ~external_clock_in;
    end
  end

  // Strobe marks T1; type pins flip once the strobe is gone
  task automatic issue(input logic wr, input logic slow);
    @(posedge clk_sys);
    #1;
    data_direction_in = wr;
    slow_cycle_n = ~slow;
    address_strobe_in_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    address_strobe_in_n = 1'b1;
    data_direction_in = ~wr;
    slow_cycle_n = slow;
  endtask
endmodule

// file: testbench.sv
/*
  Self-checking bench for the bus timing and clock unit.
  Assumes the processor model feeds a source clock of eight clk_sys cycles.
*/
`timescale 1ns/1ps
module testbench;
  import tcu_pkg::*;
  localparam int SLOW_T = 2;
  localparam int TK = 16;
  logic clk_sys = 1'b0, reset = 1'b1, raw_reset_in_n = 1'b1, continuous_wait_n = 1'b1;
  logic [WAIT_W-1:0] wait_count_in = 4'h0;
  logic external_clock_in, address_strobe_in_n, data_direction_in, slow_cycle_n;
  logic phase1_out, phase2_out, ttl_system_clock_out, fast_clock_out, synced_reset_out_n;
  logic ready_out, read_strobe_n, write_strobe_n, data_buffer_en_n, t_state_marker_out;
  logic mon_on = 1'b0;
  logic [3:0] clk_v, clk_q;
  int num_errors = 0, comparisons = 0, cyc = 0;
  int rdy_lo, rd_lo, wr_lo, dbe_lo, mk_cnt, mk_first, mk_gap, overlap = 0;
  int last_rise [4], per [4];

  // ----------------------------------------------------------------
  // Clock, instances, monitor
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  cpu_bus_model #(.SRC_HALF(4)) i_cpu_bus_model (.clk_sys(clk_sys),
    .external_clock_in(external_clock_in), .address_strobe_in_n(address_strobe_in_n),
    .data_direction_in(data_direction_in), .slow_cycle_n(slow_cycle_n));

  bus_timing_clock_unit #(.SLOW_TSTATES(SLOW_T)) i_bus_timing_clock_unit (
    .clk_sys(clk_sys), .reset(reset), .external_clock_in(external_clock_in),
    .phase1_out(phase1_out), .phase2_out(phase2_out),
    .ttl_system_clock_out(ttl_system_clock_out), .fast_clock_out(fast_clock_out),
    .raw_reset_in_n(raw_reset_in_n), .synced_reset_out_n(synced_reset_out_n),
    .address_strobe_in_n(address_strobe_in_n), .data_direction_in(data_direction_in),
    .slow_cycle_n(slow_cycle_n), .continuous_wait_n(continuous_wait_n),
    .wait_count_in(wait_count_in), .ready_out(ready_out), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_buffer_en_n(data_buffer_en_n),
    .t_state_marker_out(t_state_marker_out));

  assign clk_v = {ttl_system_clock_out, phase2_out, phase1_out, fast_clock_out};

  // Periods of every clock output, plus cycle spans while a bus cycle is watched
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    clk_q <= clk_v;
    for (int i = 0; i < 4; i++) begin
      if (clk_v[i] === 1'b1 && clk_q[i] === 1'b0) begin
        per[i] <= cyc - last_rise[i];
        last_rise[i] <= cyc;
      end
    end
    // Outputs are unknown until the first reset edge, so skip reset cycles
    if (!reset && phase1_out !== 1'b0 && phase2_out !== 1'b0) overlap <= overlap + 1;
    if (mon_on) begin
      if (ready_out !== 1'b1) rdy_lo <= rdy_lo + 1;
      if (read_strobe_n !== 1'b1) rd_lo <= rd_lo + 1;
      if (write_strobe_n !== 1'b1) wr_lo <= wr_lo + 1;
      if (data_buffer_en_n !== 1'b1) dbe_lo <= dbe_lo + 1;
      if (t_state_marker_out !== 1'b0) begin
        mk_cnt <= mk_cnt + 1;
        if (mk_cnt == 0) mk_first <= cyc;
        else mk_gap <= cyc - mk_first;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: saw %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic start_mon(input int n);
    @(posedge clk_sys);
    #1;
    wait_count_in = n[3:0];
    rdy_lo = 0; rd_lo = 0; wr_lo = 0; dbe_lo = 0; mk_cnt = 0; mk_gap = 0;
    mon_on = 1'b1;
  endtask

  // Bounded wait for the closing marker, then let strobes settle
  task automatic end_mon();
    int k = 0;
    while (mk_cnt < 2 && k < 800) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (24) @(posedge clk_sys);
    #1;
    mon_on = 1'b0;
    check(mk_cnt, 2, "marker pulses");
  endtask

  task automatic run_cycle(input logic wr, input logic slow, input int n);
    int base;
    int span;
    base = slow ? SLOW_T : 0;
    // Strobe window: T2 (fast only), every wait state and T3
    span = (n + 2 - (slow ? 1 : 0)) * TK;
    start_mon(n);
    i_cpu_bus_model.issue(wr, slow);
    end_mon();
    check(mk_gap, (n + 2 + base) * TK, "marker spacing");
    check(rdy_lo, (n + 1 + base) * TK, "ready low span");
    if (!wr) begin
      check(rd_lo, span, "read strobe span");
      check(dbe_lo, span, "buffer enable with read");
      check(wr_lo, 0, "no write strobe on read");
    end else begin
      check(rd_lo, 0, "no read strobe on write");
      check(wr_lo, span, "write strobe span");
      check(dbe_lo, span + TK, "buffer enable through T4");
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_clocks();
    repeat (64) @(posedge clk_sys);
    #1;
    check(per[0], 8, "fast clock period");
    check(per[1], TK, "phase one period");
    check(per[2], TK, "phase two period");
    check(per[3], TK, "ttl clock period");
    check(overlap, 0, "phases overlap");
  endtask

  task automatic test_reset();
    int k = 0;
    @(posedge clk_sys);
    #1;
    raw_reset_in_n = 1'b0;
    @(posedge clk_sys);
    #1;
    check(synced_reset_out_n, 1'b1, "reset passed unsynchronised");
    while (synced_reset_out_n !== 1'b0 && k < 64) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check(synced_reset_out_n, 1'b0, "reset output asserted");
    raw_reset_in_n = 1'b1;
    k = 0;
    while (synced_reset_out_n !== 1'b1 && k < 64) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check(synced_reset_out_n, 1'b1, "reset output released");
  endtask

  task automatic test_counted();
    for (int n = 0; n < 16; n++) run_cycle(1'b0, 1'b0, n);
  endtask

  task automatic test_types();
    run_cycle(1'b1, 1'b0, 2);
    run_cycle(1'b0, 1'b1, 0);
    run_cycle(1'b1, 1'b1, 3);
  endtask

  // Hold a cycle with continuous wait after d clocks of ready low, then release
  task automatic cont_cycle(input int n0, input int d, input int n1);
    int k = 0;
    start_mon(n0);
    i_cpu_bus_model.issue(1'b0, 1'b0);
    while (ready_out !== 1'b0 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (d) @(posedge clk_sys);
    #1;
    continuous_wait_n = 1'b0;
    repeat (20 * TK) @(posedge clk_sys);
    #1;
    check(ready_out, 1'b0, "ready held by continuous wait");
    check(read_strobe_n, 1'b1, "strobe parked during hold");
    wait_count_in = n1[3:0];
    rd_lo = 0;
    continuous_wait_n = 1'b1;
    k = 0;
    while (ready_out !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check(k >= n1 * TK && k <= (n1 + 2) * TK, 1, "ready after release");
    // A zero count regenerates the strobe only in T3, after ready has risen
    end_mon();
    check(rd_lo != 0, 1, "strobe regenerated");
  endtask

  task automatic test_cont_then_count();
    cont_cycle(0, 0, 3);
  endtask

  task automatic test_cont_overrides();
    cont_cycle(15, 2 * TK, 0);
  endtask

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs under ten thousand clocks
  initial begin
    #(100 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    test_clocks();
    test_reset();
    test_counted();
    test_types();
    test_cont_then_count();
    test_cont_overrides();
    report_and_stop();
  end
endmodule
